// ### hdl/ssc_map.vh
// Register offsets, field positions and reset values of the serial configuration bank
`ifndef SSC_MAP_VH
`define SSC_MAP_VH

`define SSC_ADDR_CFG_A      15'h0000
`define SSC_ADDR_CFG_B      15'h0001
`define SSC_ADDR_CLASS      15'h0003
`define SSC_ADDR_PART_LO    15'h0004
`define SSC_ADDR_PART_HI    15'h0005
`define SSC_ADDR_SCRATCH    15'h000a
`define SSC_ADDR_MAKER_LO   15'h000c
`define SSC_ADDR_MAKER_HI   15'h000d
`define SSC_ADDR_INT_LO     15'h0010
`define SSC_ADDR_OUT_INT_HI 15'h0011
`define SSC_ADDR_FRAC_B0    15'h0012
`define SSC_ADDR_FRAC_B1    15'h0013

`define SSC_CFG_SOFT_RESET  0
`define SSC_CFG_LSB_FIRST   1
`define SSC_CFG_ADDR_UP     2
`define SSC_CFG_FOUR_WIRE   3
`define SSC_CFGB_SINGLE     7
`define SSC_CFGB_MAIN_RB    5
`define SSC_CFGB_WR_MASK    8'hf6
`define SSC_OUT_INVERT      4

`define SSC_RST_CFG_A       4'h0
`define SSC_RST_CFG_B       8'h00
`define SSC_RST_SCRATCH     8'h00
`define SSC_RST_INT_LO      8'h80
`define SSC_RST_BYTE        8'h00

`define SSC_INSTR_LAST      4'hf
`define SSC_BYTE_LAST       4'h7
`define SSC_PIN_RST         3'b100

`endif

// ### hdl/ssc_sync.v
// Two-flop synchroniser for a group of pin inputs
`default_nettype none

module ssc_sync #(
	parameter       WIDTH   = 1,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
	input  wire             clk,     // Sampling clock
	input  wire             reset,   // Async reset, active high
	input  wire [WIDTH-1:0] d,       // Asynchronous inputs
	output reg  [WIDTH-1:0] q        // Synchronised outputs
);
	reg [WIDTH-1:0] meta;

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			meta <= RST_VAL;
			q    <= RST_VAL;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule // ssc_sync

`default_nettype wire

// ### hdl/ssc_regs.v
// Serial configuration register bank with its SPI slave
//
// Contract
// [R1] Config bit 3 clear gives three-wire; set enables serial out, data pin input only.
// [R2] Streaming address decrements when config bit 2 clear, increments when set.
// [R3] Config bit 1 selects MSB-first when clear, LSB-first when set.
// [R4] Writing config bit 0 resets all other registers, then the bit self-clears.
// [R5] Second config bit 7 set disables streaming: one register per transfer.
// [R6] Double-buffered fields read subordinate copy when bit 5 clear, main when set.
// [R7] Integer word: low byte at 0x10, top nibble low in 0x11; 0x10 write triggers calibration.
// [R8] Output control bit 4 inverts both RF outputs when set.
// [R9] Lowest sixteen bits of the 25-bit fraction word held low byte then middle.
// [R10] Upper config nibble mirrors lower nibble in reversed bit order.
// [R11] Divider codes 000 to 100 select divide by 1, 2, 4, 8, 16.
// [R12] Calibration triggers only while the external calibration enable is set.
// [R13] Fraction bits 23 to 16 and bit 24 live in the following registers.
`include "ssc_map.vh"
`default_nettype none

module ssc_regs #(
	parameter [3:0]  CHIP_CLASS = 4'h3,      // Arbitrary identity value
	parameter [15:0] PART_CODE  = 16'h0101,  // Arbitrary identity value
	parameter [15:0] MAKER_CODE = 16'h0a0b   // Arbitrary identity value
) (
	input  wire        CLK,                   // System clock, 40 MHz
	input  wire        RESET,                 // Async reset, active high
	input  wire        SCLK,                  // Serial clock pin
	input  wire        CS_N,                  // Chip select pin, active low
	input  wire        SDIO_IN,               // Data pin, input side
	output reg         SDIO_OUT,              // Data pin, output side
	output reg         SDIO_OE_N,             // Data pin enable, low drives
	output reg         SDO_OUT,               // Serial out pin level
	output reg         SDO_OE_N,              // Serial out enable, low drives
	input  wire        CAL_ENABLE,            // Calibration enable from upper bank
	output reg         CAL_START,             // One-cycle calibration trigger
	output reg  [11:0] N_INT,                 // Integer divider word, main copy
	output reg  [15:0] FIRST_FRACTION_LOW,    // Fraction word bits 15..0, main
	output reg  [4:0]  OUTPUT_DIVIDE_RATIO,   // Decoded divide ratio, 0 if unused
	output reg         OUTPUT_INVERT,         // Invert both RF outputs
	output reg         FOUR_WIRE_SELECT       // Four-wire mode active
);
	wire [2:0] pins;
	reg        sclk_d;
	reg  [3:0] cfg_low;
	reg  [7:0] cfg_b;
	reg  [7:0] scratch;
	reg  [7:0] int_lo;
	reg  [3:0] out_hi;
	reg  [3:0] int_hi_sub;
	reg  [3:0] int_hi_main;
	reg  [7:0] frac0_sub;
	reg  [7:0] frac0_main;
	reg  [7:0] frac1_sub;
	reg  [7:0] frac1_main;
	reg        soft_pend;
	reg        in_instr;
	reg  [3:0] bit_cnt;
	reg  [15:0] sr;
	reg  [15:0] next_sr;
	reg        rw;
	reg  [14:0] addr;
	reg  [14:0] next_addr;
	reg        done;
	reg        drive;
	reg  [7:0] tx;
	reg        sout;

	ssc_sync #(
		.WIDTH   (3),
		.RST_VAL (`SSC_PIN_RST)
	) u_sync (
		.clk   (CLK),
		.reset (RESET),
		.d     ({CS_N, SCLK, SDIO_IN}),
		.q     (pins)
	);

	wire cs_act = ~pins[2];
	wire rise   = pins[1] & ~sclk_d;
	wire fall   = ~pins[1] & sclk_d;
	wire lsb    = cfg_low[`SSC_CFG_LSB_FIRST];
	wire mainrb = cfg_b[`SSC_CFGB_MAIN_RB];

	function [7:0] rd_byte;
		input [14:0] a;
		begin
			case (a)
				`SSC_ADDR_CFG_A:      rd_byte = {cfg_low[0], cfg_low[1], cfg_low[2],
						cfg_low[3], cfg_low};                          // R10
				`SSC_ADDR_CFG_B:      rd_byte = cfg_b & `SSC_CFGB_WR_MASK;
				`SSC_ADDR_CLASS:      rd_byte = {4'h0, CHIP_CLASS};
				`SSC_ADDR_PART_LO:    rd_byte = PART_CODE[7:0];
				`SSC_ADDR_PART_HI:    rd_byte = PART_CODE[15:8];
				`SSC_ADDR_SCRATCH:    rd_byte = scratch;
				`SSC_ADDR_MAKER_LO:   rd_byte = MAKER_CODE[7:0];
				`SSC_ADDR_MAKER_HI:   rd_byte = MAKER_CODE[15:8];
				`SSC_ADDR_INT_LO:     rd_byte = int_lo;
				`SSC_ADDR_OUT_INT_HI: rd_byte = {out_hi, mainrb ? int_hi_main : int_hi_sub}; // R6
				`SSC_ADDR_FRAC_B0:    rd_byte = mainrb ? frac0_main : frac0_sub;             // R6
				`SSC_ADDR_FRAC_B1:    rd_byte = mainrb ? frac1_main : frac1_sub;             // R6
				default:              rd_byte = 8'h00;
			endcase
		end
	endfunction

	// First bit on the wire depends on the bit order
	function first_bit;
		input [7:0] b;
		input       l;
		begin
			first_bit = l ? b[0] : b[7];
		end
	endfunction

	// Bit position of the incoming bit depends on order and phase
	always @* begin
		next_sr = sr;
		if (in_instr)
			next_sr[lsb ? bit_cnt : 4'hf - bit_cnt] = pins[0];                    // R3
		else
			next_sr[lsb ? bit_cnt[2:0] : 3'h7 - bit_cnt[2:0]] = pins[0];          // R3
		if (cfg_low[`SSC_CFG_ADDR_UP])
			next_addr = addr + 15'h0001;                                          // R2
		else
			next_addr = addr - 15'h0001;                                          // R2
	end

	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			sclk_d      <= 1'b0;
			cfg_low     <= `SSC_RST_CFG_A;
			cfg_b       <= `SSC_RST_CFG_B;
			scratch     <= `SSC_RST_SCRATCH;
			int_lo      <= `SSC_RST_INT_LO;
			out_hi      <= 4'h0;
			int_hi_sub  <= 4'h0;
			int_hi_main <= 4'h0;
			frac0_sub   <= `SSC_RST_BYTE;
			frac0_main  <= `SSC_RST_BYTE;
			frac1_sub   <= `SSC_RST_BYTE;
			frac1_main  <= `SSC_RST_BYTE;
			soft_pend   <= 1'b0;
			in_instr    <= 1'b1;
			bit_cnt     <= 4'h0;
			sr          <= 16'h0000;
			rw          <= 1'b0;
			addr        <= 15'h0000;
			done        <= 1'b0;
			drive       <= 1'b0;
			tx          <= 8'h00;
			sout        <= 1'b0;
			CAL_START   <= 1'b0;
		end else begin
			sclk_d    <= pins[1];
			CAL_START <= 1'b0;
			soft_pend <= 1'b0;
			// Config register itself survives the soft reset
			if (soft_pend) begin                                                  // R4
				cfg_b       <= `SSC_RST_CFG_B;
				scratch     <= `SSC_RST_SCRATCH;
				int_lo      <= `SSC_RST_INT_LO;
				out_hi      <= 4'h0;
				int_hi_sub  <= 4'h0;
				int_hi_main <= 4'h0;
				frac0_sub   <= `SSC_RST_BYTE;
				frac0_main  <= `SSC_RST_BYTE;
				frac1_sub   <= `SSC_RST_BYTE;
				frac1_main  <= `SSC_RST_BYTE;
			end
			if (!cs_act) begin
				in_instr <= 1'b1;
				bit_cnt  <= 4'h0;
				done     <= 1'b0;
				drive    <= 1'b0;
			end else if (rise && !done) begin
				sr      <= next_sr;
				bit_cnt <= bit_cnt + 4'h1;
				if (in_instr && bit_cnt == `SSC_INSTR_LAST) begin
					in_instr <= 1'b0;
					bit_cnt  <= 4'h0;
					rw       <= next_sr[15];
					addr     <= next_sr[14:0];
					drive    <= next_sr[15];
					tx       <= rd_byte(next_sr[14:0]);
					sout     <= first_bit(rd_byte(next_sr[14:0]), lsb);           // R3
				end else if (!in_instr && bit_cnt == `SSC_BYTE_LAST) begin
					bit_cnt <= 4'h0;
					addr    <= next_addr;                                         // R2
					if (!rw) begin
						case (addr)
							`SSC_ADDR_CFG_A: begin
								// Mirror and low bits are OR-ed; bit 0 never stored
								cfg_low <= {next_sr[3] | next_sr[4], next_sr[2] | next_sr[5],
									next_sr[1] | next_sr[6], 1'b0};               // R10 R1
								soft_pend <= next_sr[0] | next_sr[7];            // R4
							end
							`SSC_ADDR_CFG_B:   cfg_b   <= next_sr[7:0] & `SSC_CFGB_WR_MASK;
							`SSC_ADDR_SCRATCH: scratch <= next_sr[7:0];
							`SSC_ADDR_INT_LO: begin
								// Writing the low byte commits every buffered field
								int_lo      <= next_sr[7:0];                     // R7
								int_hi_main <= int_hi_sub;
								frac0_main  <= frac0_sub;
								frac1_main  <= frac1_sub;
								CAL_START   <= CAL_ENABLE;                       // R7 R12
							end
							`SSC_ADDR_OUT_INT_HI: begin
								out_hi     <= next_sr[7:4];
								int_hi_sub <= next_sr[3:0];                      // R7
							end
							`SSC_ADDR_FRAC_B0: frac0_sub <= next_sr[7:0];       // R9
							`SSC_ADDR_FRAC_B1: frac1_sub <= next_sr[7:0];       // R9
							default: ;
						endcase
					end
					if (cfg_b[`SSC_CFGB_SINGLE]) begin
						done  <= 1'b1;                                            // R5
						drive <= 1'b0;
					end else if (rw) begin
						tx   <= rd_byte(next_addr);
						sout <= first_bit(rd_byte(next_addr), lsb);               // R3
					end
				end
			end else if (fall && drive && !in_instr && bit_cnt != 4'h0) begin
				sout <= tx[lsb ? bit_cnt[2:0] : 3'h7 - bit_cnt[2:0]];              // R3
			end
		end
	end

	// Pin and field outputs, all registered
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			SDIO_OUT            <= 1'b0;
			SDIO_OE_N           <= 1'b1;
			SDO_OUT             <= 1'b0;
			SDO_OE_N            <= 1'b1;
			N_INT               <= 12'h080;
			FIRST_FRACTION_LOW  <= 16'h0000;
			OUTPUT_DIVIDE_RATIO <= 5'h01;
			OUTPUT_INVERT       <= 1'b0;
			FOUR_WIRE_SELECT    <= 1'b0;
		end else begin
			SDIO_OUT            <= sout;
			SDO_OUT             <= sout;
			SDIO_OE_N           <= ~(drive & ~cfg_low[`SSC_CFG_FOUR_WIRE]);  // R1
			SDO_OE_N            <= ~(drive & cfg_low[`SSC_CFG_FOUR_WIRE]);   // R1
			FOUR_WIRE_SELECT    <= cfg_low[`SSC_CFG_FOUR_WIRE];              // R1
			N_INT               <= {int_hi_main, int_lo};                    // R7
			// Bits 24..16 are held by the neighbouring bank
			FIRST_FRACTION_LOW  <= {frac1_main, frac0_main};                 // R9 R13
			OUTPUT_INVERT       <= out_hi[`SSC_OUT_INVERT - 4];              // R8
			case (out_hi[3:1])                                               // R11
				3'h0:    OUTPUT_DIVIDE_RATIO <= 5'h01;
				3'h1:    OUTPUT_DIVIDE_RATIO <= 5'h02;
				3'h2:    OUTPUT_DIVIDE_RATIO <= 5'h04;
				3'h3:    OUTPUT_DIVIDE_RATIO <= 5'h08;
				3'h4:    OUTPUT_DIVIDE_RATIO <= 5'h10;
				default: OUTPUT_DIVIDE_RATIO <= 5'h00;
			endcase
		end
	end
endmodule // ssc_regs

`default_nettype wire

// ### sim/ssc_regs_checker.sv
// Port-level assertions for the serial configuration bank
`default_nettype none
module ssc_regs_checker (
	input wire logic        CLK,                 // Clock
	input wire logic        RESET,               // Reset
	input wire logic        CS_N,                // Select
	input wire logic        SDIO_OE_N,           // Data enable
	input wire logic        SDO_OE_N,            // Out enable
	input wire logic        CAL_ENABLE,          // Cal enable
	input wire logic        CAL_START,           // Cal pulse
	input wire logic [11:0] N_INT,               // Integer word
	input wire logic [15:0] FIRST_FRACTION_LOW,  // Fraction low
	input wire logic [4:0]  OUTPUT_DIVIDE_RATIO, // Ratio
	input wire logic        FOUR_WIRE_SELECT     // Wire mode
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	sequence s_idle; CS_N [*8]; endsequence
	sequence s_pulse; CAL_START ##1 !CAL_START; endsequence
	a_three_wire_oe: assert property (!SDIO_OE_N |-> !FOUR_WIRE_SELECT)
		else $error("data pin driven in 4-wire");
	a_four_wire_oe: assert property (!SDO_OE_N |-> FOUR_WIRE_SELECT)
		else $error("serial out driven in 3-wire");
	a_idle_release: assert property (s_idle |-> SDIO_OE_N && SDO_OE_N)
		else $error("pin driven while idle");
	a_cal_single: assert property (CAL_START |-> s_pulse)
		else $error("cal pulse too long");
	a_cal_enable: assert property (CAL_START |-> $past(CAL_ENABLE))
		else $error("cal while disabled");
	a_cal_idle: assert property (s_idle |-> !CAL_START)
		else $error("cal outside transfer");
	a_ratio_legal: assert property (OUTPUT_DIVIDE_RATIO inside
		{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10})
		else $error("bad ratio");
	a_words_quiet: assert property (s_idle |=> $stable(N_INT) && $stable(FIRST_FRACTION_LOW))
		else $error("word moved while idle");
endmodule // ssc_regs_checker
bind ssc_regs ssc_regs_checker u_chk (.CLK, .RESET, .CS_N, .SDIO_OE_N, .SDO_OE_N, .CAL_ENABLE,
	.CAL_START, .N_INT, .FIRST_FRACTION_LOW, .OUTPUT_DIVIDE_RATIO, .FOUR_WIRE_SELECT);
`default_nettype wire

// ### sim/ssc_host.sv
// SPI host model for the serial configuration bank
`default_nettype none
module ssc_host (
	input  wire logic CLK,       // Clock
	input  wire logic SDIO_OUT,  // Device data
	input  wire logic SDIO_OE_N, // Device data enable
	input  wire logic SDO_OUT,   // Device serial out
	input  wire logic SDO_OE_N,  // Serial out enable
	output var  logic SCLK,      // Serial clock
	output var  logic CS_N,      // Select
	output wire logic SDIO_IN    // Resolved data wire
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       h = 1'b0, drv = 1'b1, lsb = 1'b0, four = 1'b0;
	logic [7:0] rx [4];
	// No pull on the wire: once released it shows the inverse of the last level
	assign SDIO_IN = !SDIO_OE_N ? SDIO_OUT : (drv ? h : ~h);
	initial begin
		SCLK = 1'b0;
		CS_N = 1'b1;
	end
	// Sample just before the rise: the device moves its bit a few clocks after a fall
	task automatic bit_io(input logic b, output logic r);
		SCLK <= 1'b0;
		h <= b;
		repeat (6) @(posedge CLK);
		r = four ? (SDO_OE_N ? ~SDO_OUT : SDO_OUT) : SDIO_IN;
		SCLK <= 1'b1;
		repeat (6) @(posedge CLK);
	endtask
	task automatic xfer(input logic rd, input logic [14:0] a, input int n, input logic [7:0] wd [4]);
		logic [15:0] ins;
		logic        r;
		ins = {rd, a};
		CS_N <= 1'b0;
		repeat (6) @(posedge CLK);
		for (int i = 0; i < 16; i++) bit_io(ins[lsb ? i : 15 - i], r);
		drv <= !rd;
		for (int k = 0; k < n; k++)
			for (int j = 0; j < 8; j++) bit_io(wd[k][lsb ? j : 7 - j], rx[k][lsb ? j : 7 - j]);
		CS_N <= 1'b1;
		drv <= 1'b1;
		repeat (8) @(posedge CLK);
	endtask
endmodule // ssc_host
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the serial configuration bank
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       CLK = 1'b0, RESET = 1'b1, CAL_ENABLE = 1'b1;
	wire        SCLK, CS_N, SDIO_IN, SDIO_OUT, SDIO_OE_N, SDO_OUT, SDO_OE_N;
	wire        CAL_START, OUTPUT_INVERT, FOUR_WIRE_SELECT;
	wire [11:0] N_INT;
	wire [15:0] FIRST_FRACTION_LOW;
	wire [4:0]  OUTPUT_DIVIDE_RATIO;
	int         n_errors = 0, tests_run = 0, n_cal = 0;
	logic [7:0] wd [4];
	initial forever #12.5 CLK = ~CLK;
	always @(posedge CLK) if (CAL_START === 1'b1) n_cal <= n_cal + 1;
	// Identity values are arbitrary
	ssc_regs #(.PART_CODE(16'h1234), .MAKER_CODE(16'h4321)) DUT (.CLK, .RESET, .SCLK, .CS_N,
		.SDIO_IN, .SDIO_OUT, .SDIO_OE_N, .SDO_OUT, .SDO_OE_N, .CAL_ENABLE, .CAL_START, .N_INT,
		.FIRST_FRACTION_LOW, .OUTPUT_DIVIDE_RATIO, .OUTPUT_INVERT, .FOUR_WIRE_SELECT);
	ssc_host host (.CLK, .SDIO_OUT, .SDIO_OE_N, .SDO_OUT, .SDO_OE_N, .SCLK, .CS_N, .SDIO_IN);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		wd[0] = d;
		host.xfer(1'b0, a, 1, wd);
	endtask
	task automatic rd(input logic [14:0] a, input logic [7:0] e);
		host.xfer(1'b1, a, 1, wd);
		chk(host.rx[0], e);
	endtask
	task automatic test_done;
		$display("checks=%0d errors=%0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#2000000;
		n_errors++;
		test_done;
	end
	initial begin
		repeat (5) @(posedge CLK);
		RESET <= 1'b0;
		repeat (4) @(posedge CLK);
		rd(15'h0010, 8'h80);
		chk(OUTPUT_DIVIDE_RATIO, 5'h01);
		wr(15'h0004, 8'hff);
		rd(15'h0004, 8'h34);
		rd(15'h0002, 8'h00);
		// Descending stream ends on the low integer byte, committing the main copy
		wd = '{8'hb1, 8'hb0, 8'h9a, 8'h5c};
		host.xfer(1'b0, 15'h0013, 4, wd);
		chk(N_INT, 12'ha5c);
		chk(FIRST_FRACTION_LOW, 16'hb1b0);
		chk(n_cal, 16'h0001);
		CAL_ENABLE <= 1'b0;
		wr(15'h0010, 8'h11);
		chk(n_cal, 16'h0001);
		CAL_ENABLE <= 1'b1;
		wr(15'h0011, 8'h93);
		rd(15'h0011, 8'h93);
		wr(15'h0001, 8'h20);
		rd(15'h0011, 8'h9a);
		for (int c = 0; c < 8; c++) begin
			wr(15'h0011, {c[2:0], c[0], 4'h0});
			chk(OUTPUT_DIVIDE_RATIO, c < 5 ? 5'h01 << c : 5'h00);
			chk(OUTPUT_INVERT, c[0]);
		end
		wr(15'h0000, 8'h04);
		rd(15'h0000, 8'h24);
		host.xfer(1'b1, 15'h000c, 2, wd);
		chk({host.rx[1], host.rx[0]}, 16'h4321);
		wr(15'h0000, 8'h42);
		host.lsb = 1'b1;
		rd(15'h0000, 8'h42);
		wr(15'h000a, 8'h1e);
		rd(15'h000a, 8'h1e);
		wr(15'h0000, 8'h18);
		host.lsb = 1'b0;
		host.four = 1'b1;
		chk(FOUR_WIRE_SELECT, 1'b1);
		rd(15'h000a, 8'h1e);
		wr(15'h0001, 8'h80);
		wd = '{8'haa, 8'hbb, 8'h00, 8'h00};
		host.xfer(1'b0, 15'h0013, 2, wd);
		rd(15'h0012, 8'hb0);
		wr(15'h0000, 8'h81);
		host.four = 1'b0;
		rd(15'h000a, 8'h00);
		rd(15'h0001, 8'h00);
		rd(15'h0000, 8'h00);
		chk(N_INT, 12'h080);
		chk(FOUR_WIRE_SELECT, 1'b0);
		test_done;
	end
endmodule // tb_top
`default_nettype wire
